/* File: tb/eeprom_front_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_front_properties
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Link.
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_m_out,
	input wire logic sda_m_oe,
	input wire logic sda_s_out,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence stop_s;
		scl && $past(scl) && $rose(sda);
	endsequence
	slave_low_only_a: assert property (sda_s_oe |-> !sda_s_out)
		else $error("memory drives data high");
	slave_edge_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("memory moved data while clock high");
	data_setup_a: assert property ($rose(scl) |-> $stable(sda))
		else $error("data moved at clock rise");
	ack_prompt_a: assert property ($rose(sda_s_oe) |-> !scl && $past(scl, 40))
		else $error("memory drive late or not in low phase");
	release_prompt_a: assert property ($fell(sda_s_oe) |-> !scl && $past(scl, 40))
		else $error("memory release late or not in low phase");
	ack_hold_a: assert property (sda_s_oe && $rose(scl) |-> (sda_s_oe && !sda)[*8])
		else $error("acknowledge not held in high phase");
	stop_quiet_a: assert property (stop_s |=> (!sda_s_oe)[*8])
		else $error("memory drives after stop");
	frame_owner_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(sda_m_oe))
		else $error("start or stop not made by master");
	master_low_only_a: assert property (!(scl_oe && scl_out) && !(sda_m_oe && sda_m_out))
		else $error("master drives a line high");
	ack_seen_c: cover property (sda_s_oe && $rose(scl));
	stop_seen_c: cover property (stop_s);
	start_seen_c: cover property (scl && $past(scl) && $fell(sda));
endmodule
`default_nettype wire

/* File: tb/test_serial_eeprom_bus_slave_front.sv */
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_bus_slave_front;
	import eeprom_front_pkg::*;
	localparam int         PCYC = 4000;
	localparam logic [3:0] TID  = 4'h6; // Arbitrary value.
	typedef struct packed {size_type sz; logic [2:0] st; logic [7:0] sel; logic ack;} row_type;
	localparam row_type ROWS [9] = '{'{2'h0, 3'h5, 8'h6a, 1'b1}, '{2'h0, 3'h5, 8'h6b, 1'b1},
		'{2'h0, 3'h5, 8'h68, 1'b0}, '{2'h0, 3'h5, 8'h62, 1'b0}, '{2'h1, 3'h5, 8'h68, 1'b1},
		'{2'h2, 3'h5, 8'h64, 1'b0}, '{2'h3, 3'h5, 8'h60, 1'b1}, '{2'h0, 3'h5, 8'h7a, 1'b0},
		'{2'h0, 3'h2, 8'h64, 1'b1}};
	logic       clk_sys = 1'b0;
	logic       rst_n   = 1'b0;
	logic [2:0] straps  = 3'h0;
	size_type   sz      = 2'h0;
	logic [7:0] rdat    = 8'h96;
	logic       c_valid = 1'b0;
	logic [7:0] c_byte  = 8'h00;
	logic       c_start = 1'b0, c_stop = 1'b0, c_read = 1'b0, c_nack = 1'b0;
	logic       c_ready, done, rsp_acked, read_take, rx_valid, rx_is_select;
	logic       selected, is_read, program_start, busy, last_sel;
	logic [7:0] rsp_byte, rx_byte, last_rx;
	logic [2:0] select_addr;
	int         n_fail = 0, tests_run = 0, n_rx = 0, n_prog = 0, n_busy = 0, n_take = 0;
	int         i, r0, p0, b0, t0;
	always #12.5 clk_sys = ~clk_sys;
	two_wire_if link();
	assign link.scl = ~link.scl_oe;
	assign link.sda = ~(link.sda_m_oe | link.sda_s_oe);
	eeprom_slave_front #(.PROGRAM_CYCLES(PCYC), .TYPE_ID(TID)) u_eeprom_slave_front
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .bus(link), .chip_select_straps(straps),
		.addr_bits_in_select(sz), .read_data(rdat), .read_take(read_take), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_is_select(rx_is_select), .selected(selected),
		.is_read(is_read), .select_addr(select_addr), .program_start(program_start), .busy(busy)
	);
	two_wire_master u_two_wire_master
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .bus(link), .cmd_valid(c_valid), .cmd_byte(c_byte),
		.cmd_start(c_start), .cmd_stop(c_stop), .cmd_read(c_read), .cmd_nack(c_nack),
		.cmd_ready(c_ready), .done(done), .rsp_byte(rsp_byte), .rsp_acked(rsp_acked)
	);
	eeprom_front_properties u_eeprom_front_properties
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .scl_out(link.scl_out), .scl_oe(link.scl_oe),
		.sda_m_out(link.sda_m_out), .sda_m_oe(link.sda_m_oe), .sda_s_out(link.sda_s_out),
		.sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda)
	);
	always @(posedge clk_sys)
	begin
		if (rx_valid === 1'b1)
		begin
			n_rx <= n_rx + 1;
			last_rx <= rx_byte;
			last_sel <= rx_is_select;
		end
		if (read_take === 1'b1)
			n_take <= n_take + 1;
		if (program_start === 1'b1)
			n_prog <= n_prog + 1;
		if (busy === 1'b1)
			n_busy <= n_busy + 1;
	end
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic hang();
		n_fail++;
		$display("MISMATCH t=%0t wait ran out", $time);
		end_sim();
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t bit %b want %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t value %h want %h", $time, got, exp);
		end
	endtask
	// Flags are {start, stop, read, nack}; waits for the master's done pulse.
	task automatic cmd(input logic [7:0] b, input logic [3:0] f);
		int k;
		@(negedge clk_sys);
		for (k = 0; c_ready !== 1'b1; k++)
		begin
			if (k > 4000)
				hang();
			@(negedge clk_sys);
		end
		{c_start, c_stop, c_read, c_nack} = f;
		c_byte = b;
		c_valid = 1'b1;
		@(negedge clk_sys);
		c_valid = 1'b0;
		for (k = 0; done !== 1'b1; k++)
		begin
			if (k > 4000)
				hang();
			@(negedge clk_sys);
		end
	endtask
	initial
	begin
		repeat (20) @(negedge clk_sys);
		chk_bit(busy, 1'b0);
		chk_bit(link.sda_s_oe, 1'b0);
		rst_n = 1'b1;
		$display("reset test done");
		repeat (8) @(negedge clk_sys);
		p0 = n_prog;
		t0 = n_take;
		foreach (ROWS[k])
		begin
			sz = ROWS[k].sz;
			straps = ROWS[k].st;
			cmd(ROWS[k].sel, {1'b1, !(ROWS[k].ack && ROWS[k].sel[0]), 2'b00});
			chk_bit(rsp_acked, ROWS[k].ack);
			if (ROWS[k].ack)
			begin
				chk_val(32'(last_rx), 32'(ROWS[k].sel));
				chk_bit(last_sel, 1'b1);
				chk_bit(is_read, ROWS[k].sel[0]);
				chk_val(32'(select_addr), 32'(ROWS[k].sel[3:1]));
			end
			if (ROWS[k].ack && ROWS[k].sel[0])
			begin
				chk_bit(is_read, 1'b1);
				cmd(8'h00, 4'b0010);
				chk_val(32'(rsp_byte), 32'(rdat));
				chk_bit(selected, 1'b1);
				cmd(8'h00, 4'b0111);
				chk_val(32'(rsp_byte), 32'(rdat));
				repeat (10) @(negedge clk_sys);
				chk_bit(selected, 1'b0);
			end
			repeat (8) @(negedge clk_sys);
			$display("row %0d done", k);
		end
		chk_val(n_prog - p0, 0);
		chk_val(n_take - t0, 2);
		sz = 2'h0;
		straps = 3'h5;
		r0 = n_rx;
		b0 = n_busy;
		cmd(8'h6a, 4'b1000);
		chk_bit(rsp_acked, 1'b1);
		cmd(8'h3c, 4'b0100);
		chk_bit(rsp_acked, 1'b1);
		chk_val(32'(last_rx), 32'h3c);
		chk_bit(last_sel, 1'b0);
		chk_val(n_rx - r0, 2);
		repeat (10) @(negedge clk_sys);
		chk_val(n_prog - p0, 1);
		chk_bit(busy, 1'b1);
		cmd(8'h6a, 4'b1100);
		chk_bit(rsp_acked, 1'b0);
		for (i = 0; busy !== 1'b0; i++)
		begin
			if (i > 2 * PCYC)
				hang();
			@(negedge clk_sys);
		end
		chk_val(n_busy - b0, PCYC);
		repeat (8) @(negedge clk_sys);
		cmd(8'h6a, 4'b1100);
		chk_bit(rsp_acked, 1'b1);
		$display("write test done");
		cmd(8'h6a, 4'b1000);
		chk_bit(rsp_acked, 1'b1);
		chk_bit(selected, 1'b1);
		rst_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk_bit(link.sda_s_oe, 1'b0);
		chk_bit(selected, 1'b0);
		rst_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		cmd(8'h6a, 4'b1100);
		chk_bit(rsp_acked, 1'b1);
		$display("mid-run reset test done");
		end_sim();
	end
endmodule
`default_nettype wire

/* File: verilog/eeprom_front_params.svh */
// What this block does
// - Stop: data rises while clock high.
// - Start: data falls while clock high.
// - Stop ends transfer, await new start.
// - Read ends standby only after nack+stop.
// - Write stop launches 5 ms programming.
// - Ignore bus while programming; else watch start.
// - Transmitter releases data after 8 bits.
// - Receiver pulls data low on 9th pulse.
// - Device samples data on clock rise.
// - Master changes data only while clock low.
// - Master sends select code MSB first, 8 bits.
// - Top 4 select bits match type identifier.
// - Next 3 bits match used chip straps.
// - Address-carrying select bits skip strap compare.
// - Eighth bit: one read, zero write.
// - Matched select code gets acknowledge.
// - Mismatch: stay released, ignore, standby.
`ifndef EEPROM_FRONT_PARAMS_SVH
`define EEPROM_FRONT_PARAMS_SVH
`define CLK_SYS_HZ            40000000
`define PROGRAM_CYCLE_TIME_MS 5
`define PROGRAM_CYCLE_CYCLES  ((`CLK_SYS_HZ / 1000) * `PROGRAM_CYCLE_TIME_MS)
`define LINK_HALF_CYCLES      100
`define TYPE_ID_DEFAULT       4'h5
`define BIT_COUNT_BYTE        4'h8
`define BIT_COUNT_ACK         4'h9
`endif

/* File: verilog/eeprom_front_pkg.sv */
`default_nettype none
package eeprom_front_pkg;
	typedef enum logic [4:0]
	{
		SL_IDLE = 5'h01,
		SL_RECV = 5'h02,
		SL_SEND = 5'h04,
		SL_ACK  = 5'h08,
		SL_MACK = 5'h10
	} slave_state_type;
	typedef enum logic [4:0]
	{
		MS_IDLE  = 5'h01,
		MS_START = 5'h02,
		MS_BIT   = 5'h04,
		MS_STOP  = 5'h08,
		MS_DONE  = 5'h10
	} master_state_type;
	// Size selector: number of select bits that carry address, 0 to 3.
	typedef logic [1:0] size_type;
endpackage
`default_nettype wire

/* File: verilog/eeprom_slave_front.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_front_params.svh"
module eeprom_slave_front
	import eeprom_front_pkg::*;
#(
	parameter int        PROGRAM_CYCLES = `PROGRAM_CYCLE_CYCLES,
	parameter logic [3:0] TYPE_ID       = `TYPE_ID_DEFAULT // Arbitrary value.
)
(
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Bus.
	two_wire_if.memory      bus,
	// Straps and configuration.
	input  wire logic [2:0] chip_select_straps,
	input  wire size_type   addr_bits_in_select,
	// Memory side.
	input  wire logic [7:0] read_data,
	output logic            read_take,
	output logic [7:0]      rx_byte,
	output logic            rx_valid,
	output logic            rx_is_select,
	output logic            selected,
	output logic            is_read,
	output logic [2:0]      select_addr,
	output logic            program_start,
	output logic            busy
);
	logic [2:0] scl_sync, sda_sync;
	logic       scl_level, sda_level;
	logic       next_scl_level, next_sda_level;
	slave_state_type state, next_state;
	logic [3:0]  bit_cnt, next_bit_cnt;
	logic [7:0]  shift, next_shift;
	logic        first, next_first;
	logic        wrote, next_wrote;
	logic        sda_low, next_sda_low;
	logic [31:0] prog_cnt, next_prog_cnt;
	logic        next_selected, next_is_read, next_rx_valid, next_rx_is_select;
	logic [7:0]  next_rx_byte;
	logic [2:0]  next_select_addr;
	logic        next_program_start, next_read_take;
	logic        scl_rise, scl_fall, start_ev, stop_ev;

	function automatic logic select_match(input logic [7:0] code, input logic [2:0] straps,
		input size_type nadr);
		logic [2:0] mask;
		mask = 3'h7 << nadr;
		select_match = (code[7:4] == TYPE_ID) &&
			(((code[3:1] ^ straps) & mask) == 3'h0);
	endfunction

	always_comb
	begin
		next_scl_level = scl_level;
		next_sda_level = sda_level;
		if (scl_sync[1] == scl_sync[2])
		begin
			next_scl_level = scl_sync[2];
		end
		if (sda_sync[1] == sda_sync[2])
		begin
			next_sda_level = sda_sync[2];
		end
	end

	assign scl_rise = next_scl_level & ~scl_level;
	assign scl_fall = ~next_scl_level & scl_level;
	assign start_ev = scl_level & next_scl_level & sda_level & ~next_sda_level;
	assign stop_ev  = scl_level & next_scl_level & ~sda_level & next_sda_level;

	always_comb
	begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_first = first;
		next_wrote = wrote;
		next_sda_low = sda_low;
		next_prog_cnt = prog_cnt;
		next_selected = selected;
		next_is_read = is_read;
		next_rx_valid = 1'b0;
		next_rx_is_select = rx_is_select;
		next_rx_byte = rx_byte;
		next_select_addr = select_addr;
		next_program_start = 1'b0;
		next_read_take = 1'b0;
		if (prog_cnt != 32'h0)
		begin
			next_prog_cnt = prog_cnt - 32'h1;
			next_state = SL_IDLE;
			next_sda_low = 1'b0;
		end
		else if (stop_ev)
		begin
			next_state = SL_IDLE;
			next_sda_low = 1'b0;
			next_selected = 1'b0;
			if (wrote)
			begin
				next_prog_cnt = 32'(PROGRAM_CYCLES);
				next_program_start = 1'b1;
			end
			next_wrote = 1'b0;
		end
		else if (start_ev)
		begin
			next_state = SL_RECV;
			next_bit_cnt = 4'h0;
			next_first = 1'b1;
			next_sda_low = 1'b0;
			next_wrote = 1'b0;
		end
		else
		begin
			case (state)
				SL_IDLE:
				begin
					next_sda_low = 1'b0;
				end
				SL_RECV:
				begin
					if (scl_rise)
					begin
						next_shift = {shift[6:0], sda_level};
						next_bit_cnt = bit_cnt + 4'h1;
					end
					else if (scl_fall && bit_cnt == `BIT_COUNT_BYTE)
					begin
						next_bit_cnt = 4'h0;
						next_rx_byte = shift;
						next_rx_valid = 1'b1;
						next_rx_is_select = first;
						if (first)
						begin
							if (select_match(shift, chip_select_straps, addr_bits_in_select))
							begin
								next_selected = 1'b1;
								next_is_read = shift[0];
								next_select_addr = shift[3:1];
								next_sda_low = 1'b1;
								next_state = SL_ACK;
							end
							else
							begin
								next_selected = 1'b0;
								next_state = SL_IDLE;
							end
						end
						else
						begin
							next_wrote = 1'b1;
							next_sda_low = 1'b1;
							next_state = SL_ACK;
						end
						next_first = 1'b0;
					end
				end
				SL_ACK:
				begin
					if (scl_fall)
					begin
						next_sda_low = 1'b0;
						if (is_read)
						begin
							next_shift = read_data;
							next_read_take = 1'b1;
							next_sda_low = ~read_data[7];
							next_state = SL_SEND;
						end
						else
						begin
							next_state = SL_RECV;
						end
					end
				end
				SL_SEND:
				begin
					if (scl_fall)
					begin
						next_bit_cnt = bit_cnt + 4'h1;
						next_shift = {shift[6:0], 1'b0};
						if (bit_cnt == `BIT_COUNT_BYTE - 4'h1)
						begin
							next_sda_low = 1'b0;
							next_bit_cnt = 4'h0;
							next_state = SL_MACK;
						end
						else
						begin
							next_sda_low = ~shift[6];
						end
					end
				end
				SL_MACK:
				begin
					if (scl_rise)
					begin
						if (sda_level)
						begin
							next_state = SL_IDLE;
						end
						else
						begin
							next_state = SL_ACK;
						end
					end
				end
				default:
				begin
					next_state = SL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			scl_level <= 1'b1;
			sda_level <= 1'b1;
			state <= SL_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h0;
			first <= 1'b0;
			wrote <= 1'b0;
			sda_low <= 1'b0;
			prog_cnt <= 32'h0;
			selected <= 1'b0;
			is_read <= 1'b0;
			rx_valid <= 1'b0;
			rx_is_select <= 1'b0;
			rx_byte <= 8'h0;
			select_addr <= 3'h0;
			program_start <= 1'b0;
			read_take <= 1'b0;
		end
		else
		begin
			scl_sync <= {scl_sync[1:0], bus.scl};
			sda_sync <= {sda_sync[1:0], bus.sda};
			scl_level <= next_scl_level;
			sda_level <= next_sda_level;
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			first <= next_first;
			wrote <= next_wrote;
			sda_low <= next_sda_low;
			prog_cnt <= next_prog_cnt;
			selected <= next_selected;
			is_read <= next_is_read;
			rx_valid <= next_rx_valid;
			rx_is_select <= next_rx_is_select;
			rx_byte <= next_rx_byte;
			select_addr <= next_select_addr;
			program_start <= next_program_start;
			read_take <= next_read_take;
		end
	end

	// Open drain: only a low is ever driven.
	assign bus.sda_s_out = 1'b0;
	assign bus.sda_s_oe  = sda_low;
	assign busy = (prog_cnt != 32'h0);
endmodule
`default_nettype wire

/* File: verilog/two_wire_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
	logic scl_out;
	logic scl_oe;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_s_out;
	logic sda_s_oe;
	logic scl;
	logic sda;
	modport master
	(
		output scl_out, scl_oe, sda_m_out, sda_m_oe,
		input  scl, sda
	);
	modport memory
	(
		output sda_s_out, sda_s_oe,
		input  scl, sda
	);
endinterface
`default_nettype wire

/* File: verilog/two_wire_master.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_front_params.svh"
module two_wire_master
	import eeprom_front_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Bus.
	two_wire_if.master      bus,
	// Command port.
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	input  wire logic       cmd_start,
	input  wire logic       cmd_stop,
	input  wire logic       cmd_read,
	input  wire logic       cmd_nack,
	output logic            cmd_ready,
	output logic            done,
	output logic [7:0]      rsp_byte,
	output logic            rsp_acked
);
	master_state_type state, next_state;
	logic [7:0] cnt, next_cnt;
	logic [1:0] phase, next_phase;
	logic [3:0] bit_idx, next_bit_idx;
	logic [8:0] tx, next_tx;
	logic [8:0] rx, next_rx;
	logic       scl_drv, next_scl_drv, sda_drv, next_sda_drv;
	logic       want_stop, next_want_stop;
	logic       next_done, next_acked;
	logic [7:0] next_rsp;
	logic [2:0] sda_sync;
	logic       tick;

	assign tick = (cnt == 8'h0);
	assign cmd_ready = (state == MS_IDLE);

	always_comb
	begin
		next_state = state;
		next_cnt = tick ? 8'(`LINK_HALF_CYCLES / 2 - 1) : cnt - 8'h1;
		next_phase = phase;
		next_bit_idx = bit_idx;
		next_tx = tx;
		next_rx = rx;
		next_scl_drv = scl_drv;
		next_sda_drv = sda_drv;
		next_want_stop = want_stop;
		next_done = 1'b0;
		next_acked = rsp_acked;
		next_rsp = rsp_byte;
		case (state)
			MS_IDLE:
			begin
				if (cmd_valid)
				begin
					next_tx = cmd_read ? {8'hff, cmd_nack} : {cmd_byte, 1'b1};
					next_want_stop = cmd_stop;
					next_bit_idx = 4'h0;
					next_phase = 2'h0;
					next_state = cmd_start ? MS_START : MS_BIT;
				end
			end
			MS_START:
			if (tick)
			begin
				next_phase = phase + 2'h1;
				case (phase)
					2'h0: next_sda_drv = 1'b0;
					2'h1: next_scl_drv = 1'b0;
					2'h2: next_sda_drv = 1'b1;
					default: next_sda_drv = 1'b1;
				endcase
				// Repeated start raises data and clock in the same step while clock is low, then drops data.
				if (phase == 2'h0 && !scl_drv)
				begin
					next_sda_drv = 1'b1;
					next_scl_drv = 1'b1;
				end
				else if (phase == 2'h0)
				begin
					next_sda_drv = 1'b0;
				end
				if (phase == 2'h1 && sda_drv)
				begin
					next_sda_drv = 1'b0;
					next_scl_drv = 1'b1;
					next_phase = 2'h1;
				end
				if (phase == 2'h1 && !sda_drv)
				begin
					next_scl_drv = 1'b0;
					next_phase = 2'h0;
					next_state = MS_BIT;
				end
			end
			MS_BIT:
			if (tick)
			begin
				next_phase = phase + 2'h1;
				case (phase)
					2'h0: next_sda_drv = tx[8];
					2'h1: next_scl_drv = 1'b1;
					2'h2: next_rx = {rx[7:0], sda_sync[2]};
					default:
					begin
						next_scl_drv = 1'b0;
						next_tx = {tx[7:0], 1'b1};
						next_bit_idx = bit_idx + 4'h1;
						if (bit_idx == `BIT_COUNT_ACK - 4'h1)
						begin
							next_acked = ~rx[0];
							next_rsp = rx[8:1];
							next_state = want_stop ? MS_STOP : MS_DONE;
						end
					end
				endcase
			end
			MS_STOP:
			if (tick)
			begin
				next_phase = phase + 2'h1;
				case (phase)
					2'h0: next_sda_drv = 1'b0;
					2'h1: next_scl_drv = 1'b1;
					2'h2: next_sda_drv = 1'b1;
					default: next_state = MS_DONE;
				endcase
			end
			MS_DONE:
			begin
				next_done = 1'b1;
				next_state = MS_IDLE;
			end
			default: next_state = MS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state <= MS_IDLE;
			cnt <= 8'h0;
			phase <= 2'h0;
			bit_idx <= 4'h0;
			tx <= 9'h1ff;
			rx <= 9'h0;
			scl_drv <= 1'b1;
			sda_drv <= 1'b1;
			want_stop <= 1'b0;
			done <= 1'b0;
			rsp_acked <= 1'b0;
			rsp_byte <= 8'h0;
			sda_sync <= 3'h7;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			phase <= next_phase;
			bit_idx <= next_bit_idx;
			tx <= next_tx;
			rx <= next_rx;
			scl_drv <= next_scl_drv;
			sda_drv <= next_sda_drv;
			want_stop <= next_want_stop;
			done <= next_done;
			rsp_acked <= next_acked;
			rsp_byte <= next_rsp;
			sda_sync <= {sda_sync[1:0], bus.sda};
		end
	end

	assign bus.scl_out   = 1'b0;
	assign bus.scl_oe    = ~scl_drv;
	assign bus.sda_m_out = 1'b0;
	assign bus.sda_m_oe  = ~sda_drv;
endmodule
`default_nettype wire
